// [rtl/sop_macrocell_array.sv]
/*
 * Sum-of-products array with eight configurable output cells,
 * fuse map and configuration word held in Wishbone registers.
 * Assumes pins reach it asynchronously; the board resolves each
 * bidirectional pin level from io_pin_o and io_pin_oe_o.
 */
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module sop_macrocell_array (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Dedicated input pins, bit 0 clock, bit 11 low enable
    input wire logic [13:0] ded_pin_i,
    // Bidirectional cell pins
    input wire logic [7:0] io_pin_i,
    output logic [7:0] io_pin_o,
    output logic [7:0] io_pin_oe_o
);

    // ----------------------------------------------------------------
    // State and helpers
    // ----------------------------------------------------------------
    sop_pkg::sop_state_t st;
    sop_pkg::sop_state_t next_st;

    logic [21:0] sig;
    logic [43:0] lit;
    logic [43:0] col_mask;
    logic [63:0] term;
    logic [7:0] fb;
    logic [7:0] sum;
    logic clk_rise;
    logic oe_n;
    logic take;
    logic [5:0] t_idx;
    logic [31:0] old_word;
    logic [31:0] new_word;

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        sig = '0;
        lit = '0;
        col_mask = '1;
        term = '0;
        fb = '0;
        sum = '0;
        t_idx = wb_adr_i[8:3];
        old_word = '0;
        new_word = '0;

        // Three-stage pin synchronisers; a level counts once s2 and s3 agree
        next_st.ded_s1 = ded_pin_i;
        next_st.ded_s2 = st.ded_s1;
        next_st.ded_s3 = st.ded_s2;
        next_st.io_s1 = io_pin_i;
        next_st.io_s2 = st.io_s1;
        next_st.io_s3 = st.io_s2;
        for (int i = 0; i < sop_pkg::NUM_DED; i++) begin
            if (st.ded_s2[i] == st.ded_s3[i]) begin
                next_st.ded_f[i] = st.ded_s3[i];
            end
        end
        for (int i = 0; i < sop_pkg::NUM_CELLS; i++) begin
            if (st.io_s2[i] == st.io_s3[i]) begin
                next_st.io_f[i] = st.io_s3[i];
            end
        end
        clk_rise = st.ded_s2[sop_pkg::CLK_PIN]
            & st.ded_s3[sop_pkg::CLK_PIN]
            & ~st.ded_f[sop_pkg::CLK_PIN];
        oe_n = st.ded_f[sop_pkg::OE_PIN];

        // Feedback select mux
        for (int c = 0; c < sop_pkg::NUM_CELLS; c++) begin
            logic fsel;
            logic reg_cell;
            fsel = st.emul_sel;
            if (c == 0 || c == sop_pkg::NUM_CELLS - 1) begin
                fsel = ~st.reg_allow;
            end
            reg_cell = ~st.reg_allow & st.emul_sel & ~st.cfg_sel[c];
            if (reg_cell) begin
                fb[c] = ~st.q[c];
            end else if (fsel && st.cfg_sel[c]) begin
                fb[c] = st.io_f[c];
            end else if (!fsel && st.cfg_sel[c]) begin
                fb[c] = st.io_f[(c == sop_pkg::NUM_CELLS - 1) ? c - 1 : c + 1];
            end else if (!fsel && (c == 0 || c == sop_pkg::NUM_CELLS - 1)) begin
                fb[c] = 1'b0;
            end else begin
                fb[c] = st.io_f[c];
            end
        end

        // Array inputs: ten plain pins, two extra pins, clock, enable, feedback
        sig[9:0] = st.ded_f[10:1];
        sig[10] = st.ded_f[12];
        sig[11] = st.ded_f[13];
        sig[sop_pkg::CLK_SIG] = st.ded_f[sop_pkg::CLK_PIN];
        sig[sop_pkg::OE_SIG] = st.ded_f[sop_pkg::OE_PIN];
        sig[21:14] = fb;
        for (int k = 0; k < sop_pkg::NUM_SIGS; k++) begin
            lit[2*k] = sig[k];
            lit[2*k+1] = ~sig[k];
        end
        if (!st.reg_allow) begin
            col_mask[2*sop_pkg::CLK_SIG +: 4] = 4'h0;
        end

        // AND array: unconnected columns read HIGH
        for (int t = 0; t < sop_pkg::NUM_TERMS; t++) begin
            term[t] = &(~(st.fuse[t] & col_mask) | lit);
        end

        // Cells
        for (int c = 0; c < sop_pkg::NUM_CELLS; c++) begin
            logic [7:0] grp;
            logic reg_cell;
            logic io_cell;
            logic in_cell;
            grp = term[c*sop_pkg::TERMS_PER_CELL +: 8];
            reg_cell = ~st.reg_allow & st.emul_sel & ~st.cfg_sel[c];
            io_cell = st.emul_sel & st.cfg_sel[c];
            in_cell = ~st.emul_sel & st.cfg_sel[c];
            if (io_cell) begin
                sum[c] = |grp[7:1];
            end else begin
                sum[c] = |grp;
            end
            if (reg_cell) begin
                if (clk_rise && st.run) begin
                    next_st.q[c] = sum[c] ^ st.pol[c];
                end
                next_st.pin_o[c] = ~next_st.q[c];
                next_st.pin_oe[c] = ~oe_n & st.run;
            end else if (io_cell) begin
                next_st.pin_o[c] = sum[c] ^ st.pol[c];
                next_st.pin_oe[c] = grp[0] & st.run;
            end else if (in_cell) begin
                next_st.pin_o[c] = 1'b0;
                next_st.pin_oe[c] = 1'b0;
            end else begin
                next_st.pin_o[c] = sum[c] ^ st.pol[c];
                next_st.pin_oe[c] = st.run;
            end
        end

        // Wishbone slave: ack one cycle after the request is seen
        take = wb_cyc_i & wb_stb_i & ~st.ack;
        next_st.ack = take;
        if (take && wb_adr_i[11:9] == sop_pkg::FUSE_REGION) begin
            if (wb_adr_i[2]) begin
                old_word = {20'h0, st.fuse[t_idx][43:32]};
            end else begin
                old_word = st.fuse[t_idx][31:0];
            end
        end
        new_word = merge_bytes(old_word, wb_dat_i, wb_sel_i);
        if (take && wb_we_i) begin
            if (wb_adr_i == sop_pkg::ADR_CTRL && wb_sel_i[0]) begin
                next_st.run = wb_dat_i[sop_pkg::CTRL_RUN_POS];
            end else if (wb_adr_i == sop_pkg::ADR_CONFIG && !st.run) begin
                if (wb_sel_i[0]) begin
                    next_st.reg_allow = wb_dat_i[sop_pkg::CFG_ALLOW_POS];
                    next_st.emul_sel = wb_dat_i[sop_pkg::CFG_EMUL_POS];
                end
                if (wb_sel_i[1]) begin
                    next_st.cfg_sel = wb_dat_i[sop_pkg::CFG_SEL_POS +: 8];
                end
                if (wb_sel_i[2]) begin
                    next_st.pol = wb_dat_i[sop_pkg::CFG_POL_POS +: 8];
                end
            end else if (wb_adr_i[11:9] == sop_pkg::FUSE_REGION && !st.run) begin
                if (wb_adr_i[2]) begin
                    next_st.fuse[t_idx][43:32] = new_word[11:0];
                end else begin
                    next_st.fuse[t_idx][31:0] = new_word;
                end
            end
        end
        next_st.dat = '0;
        if (take && !wb_we_i) begin
            if (wb_adr_i == sop_pkg::ADR_CTRL) begin
                next_st.dat[sop_pkg::CTRL_RUN_POS] = st.run;
            end else if (wb_adr_i == sop_pkg::ADR_CONFIG) begin
                next_st.dat[sop_pkg::CFG_ALLOW_POS] = st.reg_allow;
                next_st.dat[sop_pkg::CFG_EMUL_POS] = st.emul_sel;
                next_st.dat[sop_pkg::CFG_SEL_POS +: 8] = st.cfg_sel;
                next_st.dat[sop_pkg::CFG_POL_POS +: 8] = st.pol;
            end else if (wb_adr_i == sop_pkg::ADR_STATUS) begin
                next_st.dat[sop_pkg::STAT_OUT_POS +: 8] = st.pin_o;
                next_st.dat[sop_pkg::STAT_OE_POS +: 8] = st.pin_oe;
                next_st.dat[sop_pkg::STAT_Q_POS +: 8] = st.q;
            end else if (wb_adr_i == sop_pkg::ADR_INPUTS) begin
                next_st.dat[13:0] = st.ded_f;
            end else if (wb_adr_i[11:9] == sop_pkg::FUSE_REGION) begin
                next_st.dat = old_word;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.run <= sop_pkg::RST_RUN;
            st.reg_allow <= sop_pkg::RST_ALLOW;
            st.emul_sel <= sop_pkg::RST_EMUL;
            st.cfg_sel <= sop_pkg::RST_SEL;
            st.pol <= sop_pkg::RST_POL;
            st.q <= sop_pkg::RST_Q;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_dat_o = st.dat;
    assign wb_ack_o = st.ack;
    assign io_pin_o = st.pin_o;
    assign io_pin_oe_o = st.pin_oe;

endmodule : sop_macrocell_array

`default_nettype wire

// [rtl/sop_pkg.sv]
/*
 * Constants and state type for the sum-of-products macrocell array.
 * Assumes a classic Wishbone slave port with 32-bit data and byte selects.
 */

package sop_pkg;

    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int NUM_CELLS = 8;
    localparam int TERMS_PER_CELL = 8;
    localparam int NUM_TERMS = 64;
    localparam int NUM_DED = 14;
    localparam int NUM_SIGS = 22;
    localparam int NUM_COLS = 44;
    localparam int CLK_PIN = 0;
    localparam int OE_PIN = 11;
    localparam int CLK_SIG = 12;
    localparam int OE_SIG = 13;
    localparam int FB_SIG = 14;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] ADR_CTRL = 12'h000;
    localparam logic [11:0] ADR_CONFIG = 12'h004;
    localparam logic [11:0] ADR_STATUS = 12'h008;
    localparam logic [11:0] ADR_INPUTS = 12'h00C;
    localparam logic [2:0] FUSE_REGION = 3'h1;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_RUN_POS = 0;
    localparam int CFG_ALLOW_POS = 0;
    localparam int CFG_EMUL_POS = 1;
    localparam int CFG_SEL_POS = 8;
    localparam int CFG_POL_POS = 16;
    localparam int STAT_OUT_POS = 0;
    localparam int STAT_OE_POS = 8;
    localparam int STAT_Q_POS = 16;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic RST_RUN = 1'b0;
    localparam logic RST_ALLOW = 1'b0;
    localparam logic RST_EMUL = 1'b0;
    localparam logic [7:0] RST_SEL = 8'h00;
    localparam logic [7:0] RST_POL = 8'h00;
    localparam logic [7:0] RST_Q = 8'h00;

    // ----------------------------------------------------------------
    // Block state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic run;
        logic reg_allow;
        logic emul_sel;
        logic [7:0] cfg_sel;
        logic [7:0] pol;
        logic [63:0][43:0] fuse;
        logic [13:0] ded_s1;
        logic [13:0] ded_s2;
        logic [13:0] ded_s3;
        logic [13:0] ded_f;
        logic [7:0] io_s1;
        logic [7:0] io_s2;
        logic [7:0] io_s3;
        logic [7:0] io_f;
        logic [7:0] q;
        logic [7:0] pin_o;
        logic [7:0] pin_oe;
        logic ack;
        logic [31:0] dat;
    } sop_state_t;

endpackage : sop_pkg

// [tb/sop_board.sv]
/* Board around the array: pulled-up cell pins.
   Assumes the bench drives the dedicated pins itself. */
`timescale 1ns/1ps
`default_nettype none
module sop_board (
    // Drive from the array
    input wire logic [7:0] pin_o_i,
    input wire logic [7:0] pin_oe_i,
    // Level on each cell pin
    output logic [7:0] pin_lvl_o
);
    // Released pins rise to the pull-up
    assign pin_lvl_o = (pin_o_i & pin_oe_i) | ~pin_oe_i;
endmodule : sop_board
`default_nettype wire

// [tb/sop_macrocell_array_bench.sv]
/* Bench for the macrocell array: Wishbone tasks and pin stimulus.
   Assumes the pulled-up board model on the cell pins. */
`timescale 1ns/1ps
`default_nettype none
module sop_macrocell_array_bench;
    logic clk, rst, cyc, stb, we, ack;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [13:0] ded;
    logic [7:0] lvl, pin_o, pin_oe;
    int num_errors, n_checks;

    sop_macrocell_array sop_macrocell_array_i (.clk_i(clk), .rst_i(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ded_pin_i(ded), .io_pin_i(lvl), .io_pin_o(pin_o),
        .io_pin_oe_o(pin_oe));
    sop_board sop_board_i (.pin_o_i(pin_o), .pin_oe_i(pin_oe),
        .pin_lvl_o(lvl));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic pause(input int n);
        repeat (n) @(posedge clk);
    endtask : pause

    task automatic bus(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask : bus

    task automatic rd(input logic [11:0] a, input logic [31:0] m,
            input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        n_checks++;
        if ((q & m) !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, q & m);
        end
    endtask : rd

    task automatic fill(input int c, input logic [31:0] w);
        for (int t = 0; t < 8; t++) begin
            bus(1'b1, 12'h200 + 12'(64 * c + 8 * t), w);
        end
    endtask : fill

    task automatic do_reset();
        if (rst !== 1'b1) begin
            rst <= 1'b1;
        end
        pause(8);
        rst <= 1'b0;
        pause(6);
    endtask : do_reset

    task automatic tick();
        ded[0] <= 1'b1;
        pause(4);
        ded[0] <= 1'b0;
        pause(10);
    endtask : tick

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {rst, cyc, stb, we} = 4'b1000;
        {adr, wdat, ded} = '0;
        sel = 4'hF;
        do_reset();
        rd(sop_pkg::ADR_CTRL, '1, 32'h0, "ctrl");
        rd(sop_pkg::ADR_CONFIG, '1, 32'h0, "config");
        bus(1'b1, 12'h010, '1);
        rd(12'h010, '1, 32'h0, "unmapped");
        // Registered family, cell 6 bidirectional
        fill(2, 32'h0000_0001);
        fill(3, 32'h1000_0000);
        fill(5, 32'h0100_0000);
        bus(1'b1, sop_pkg::ADR_CONFIG, 32'h0004_4002);
        ded <= 14'h0002;
        bus(1'b1, sop_pkg::ADR_CTRL, 32'h1);
        pause(10);
        rd(sop_pkg::ADR_STATUS, 32'h00BF_FFFF, 32'h0000_FFFF, "st0");
        bus(1'b1, sop_pkg::ADR_CONFIG, 32'h0);
        rd(sop_pkg::ADR_CONFIG, '1, 32'h0004_4002, "cfg held");
        tick();
        rd(sop_pkg::ADR_STATUS, 32'h00BF_FFFF, 32'h00BB_FF44, "st1");
        ded <= 14'h0802;
        pause(8);
        tick();
        rd(sop_pkg::ADR_STATUS, 32'h00BF_FFFF, 32'h00B3_404C, "st2");
        // Combinatorial device, cell 7 dedicated input
        do_reset();
        fill(2, 32'h0000_0001);
        fill(3, 32'h0000_0002);
        fill(4, 32'h0000_0003);
        fill(5, 32'h0100_0000);
        fill(6, 32'h0000_0001);
        for (int t = 0; t < 8; t++) begin
            bus(1'b1, 12'h204 + 12'(8 * t), 32'h0000_0400);
        end
        bus(1'b1, sop_pkg::ADR_CONFIG, 32'h0002_8001);
        ded <= 14'h0003;
        bus(1'b1, sop_pkg::ADR_CTRL, 32'h1);
        pause(10);
        rd(sop_pkg::ADR_STATUS, 32'h0000_FF7F, 32'h0000_7F65, "c1");
        ded <= 14'h0000;
        pause(16);
        rd(sop_pkg::ADR_STATUS, 32'h0000_FF7F, 32'h0000_7F08, "c0");
        give_verdict();
    end

    initial begin
        #50000;
        num_errors++;
        give_verdict();
    end
endmodule : sop_macrocell_array_bench
`default_nettype wire

// [tb/sop_macrocell_array_properties.sv]
/* Port checker for the macrocell array, shadowing run and config.
   Assumes full-word writes held until ack. */
`timescale 1ns/1ps
`default_nettype none
module sop_macrocell_array_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins
    input wire logic [13:0] ded_pin_i,
    input wire logic [7:0] io_pin_i,
    input wire logic [7:0] io_pin_o,
    input wire logic [7:0] io_pin_oe_o
);
    logic run, g0, g1, wr;
    logic [7:0] cs, in_m, reg_m, cmb_m;

    // ------------------------------------------------------------
    // Shadow of run and configuration
    // ------------------------------------------------------------
    assign wr = wb_ack_o && wb_we_i && wb_sel_i == 4'hF;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {run, g1, g0, cs} <= '0;
        end else if (wr && wb_adr_i == sop_pkg::ADR_CTRL) begin
            run <= wb_dat_i[0];
        end else if (wr && wb_adr_i == sop_pkg::ADR_CONFIG && !run) begin
            {cs, g1, g0} <= {wb_dat_i[15:8], wb_dat_i[1:0]};
        end
    end
    assign in_m = g1 ? 8'h00 : cs;
    assign reg_m = (g1 && !g0) ? ~cs : 8'h00;
    assign cmb_m = (g0 || !g1) ? ~cs : 8'h00;

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_quiet;
        !wb_cyc_i && $stable(ded_pin_i) && $stable(io_pin_i);
    endsequence

    a_ack_next: assert property (s_req |=> wb_ack_o)
        else $error("no ack one cycle after a request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside the ack cycle");
    a_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o
        && io_pin_o == 8'h00 && io_pin_oe_o == 8'h00)
        else $error("outputs not cleared by reset");
    a_stop_no_drive: assert property (!run [*3] |-> io_pin_oe_o == 8'h00)
        else $error("pin driven while stopped");
    a_input_no_drive: assert property ((io_pin_oe_o & in_m) == 8'h00)
        else $error("input cell drives its pin");
    a_comb_on: assert property (run [*3] |->
        (io_pin_oe_o & cmb_m) == cmb_m)
        else $error("output cell driver off");
    a_reg_enable: assert property (
        (run && $stable(ded_pin_i[sop_pkg::OE_PIN])) [*6] |->
        (io_pin_oe_o & reg_m) ==
        (ded_pin_i[sop_pkg::OE_PIN] ? 8'h00 : reg_m))
        else $error("registered driver not following enable pin");
    a_hold_still: assert property (s_quiet [*8] |->
        $stable(io_pin_o) && $stable(io_pin_oe_o))
        else $error("outputs moved with steady inputs");
endmodule : sop_macrocell_array_chk

bind sop_macrocell_array sop_macrocell_array_chk sop_macrocell_array_chk_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ded_pin_i(ded_pin_i), .io_pin_i(io_pin_i), .io_pin_o(io_pin_o),
    .io_pin_oe_o(io_pin_oe_o));
`default_nettype wire
